/* nmi_agg_regs.svh */
`ifndef NMI_AGG_REGS_SVH
`define NMI_AGG_REGS_SVH
// Byte offsets of the APB register map.
`define OFF_M_FLAGS      12'h000
`define OFF_M_CLEAR      12'h004
`define OFF_M_FORCE      12'h008
`define OFF_M_WDCTL      12'h00C
`define OFF_C_FLAGS      12'h010
`define OFF_C_CLEAR      12'h014
`define OFF_C_FORCE      12'h018
`define OFF_C_WDCTL      12'h01C
`define OFF_IRQ_STATUS   12'h020
`define OFF_IRQ_MASK     12'h024
`define OFF_WD_COUNT_M   12'h028
`define OFF_WD_COUNT_C   12'h02C
// Flag bit positions, master side.
`define M_BIT_CTRL_WD    0
`define M_BIT_VEC_ERR    1
`define M_BIT_OSC        2
`define M_BIT_ABUS       3
`define M_BIT_EXT        4
`define M_BIT_MST_BIST   5
`define M_BIT_CTL_BIST   6
// Flag bit positions, control side.
`define C_BIT_OSC        0
`define C_BIT_ABUS       1
`define C_BIT_RAM        2
`define C_BIT_FLASH      3
`define C_BIT_VEC_ERR    4
`define C_BIT_CTL_BIST   5
`define C_BIT_MST_BIST   6
// Event status bits.
`define EV_M_NMI         0
`define EV_C_NMI         1
`define EV_M_EXPIRE      2
`define EV_C_EXPIRE      3
// Reset values.
`define FLAGS_RST        7'h00
`define MASK_RST         4'h0
// Watchdog timeout in microseconds and cycles at 25 MHz.
`define WD_TIMEOUT_US    100
`define CLK_MHZ          25
`define WD_CYCLES        (`WD_TIMEOUT_US * `CLK_MHZ)
// Width of the reset pulse driven out on the system reset pin.
`define RST_PULSE_CYCLES 16
`endif

/* nmi_agg_pkg.sv */
package nmi_agg_pkg;
	typedef logic [6:0] flags_t;
	typedef struct packed {
		logic ext_emergency;
		logic analog_bus_err;
		logic osc_missing;
		logic vector_fetch_err;
		logic ram_uncorrectable;
		logic flash_uncorrectable;
		logic master_selftest_err;
		logic control_selftest_err;
	} err_src_t;
	typedef struct packed {
		logic master_nmi_irq;
		logic master_nmi_wd_arm;
		logic master_nmi_wd_reset;
		logic control_nmi_irq;
		logic control_nmi_wd_arm;
		logic control_nmi_wd_reset;
		logic control_wd_reset_source;
	} nmi_out_t;
	typedef enum logic [1:0] {WD_IDLE, WD_COUNT, WD_EXPIRED} wd_state_t;
endpackage

/* dual_nmi_aggregator.sv */
// Decided for this implementation: the register offsets and register access over APB.
`include "nmi_agg_regs.svh"
module dual_nmi_aggregator
	import nmi_agg_pkg::*;
#(
	parameter int WD_CYCLES = `WD_CYCLES
)
(
	// Clock and reset.
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	// APB slave.
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Error sources from outside the clock domain.
	input  wire err_src_t    ERR_SRC,
	input  wire logic [1:0]  GEN_WD_EXPIRE,
	// NMI and reset outputs.
	output nmi_out_t         NMI_OUT,
	output logic             RST_PIN_OUT,
	output logic             RST_PIN_OE,
	output logic             IRQ
);
	localparam logic [31:0] WD_LOAD = 32'(WD_CYCLES - 1);
	function automatic logic [31:0] zext7(input flags_t f);
		return {25'h000_0000, f};
	endfunction
	// Three-stage synchronisers; a change counts once stages two and three agree.
	logic [9:0] s1_reg;
	logic [9:0] s2_reg;
	logic [9:0] s3_reg;
	logic [9:0] src_reg;
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			s1_reg <= 10'h000;
			s2_reg <= 10'h000;
			s3_reg <= 10'h000;
			src_reg <= 10'h000;
		end
		else
		begin
			s1_reg <= {GEN_WD_EXPIRE, ERR_SRC};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < 10; i++)
				if (s2_reg[i] == s3_reg[i])
					src_reg[i] <= s3_reg[i];
		end
	end
	err_src_t src;
	assign src = err_src_t'(src_reg[7:0]);
	logic gen_wd_any;
	assign gen_wd_any = |src_reg[9:8];
	// APB decode; zero wait states.
	logic wr_en;
	logic rd_en;
	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_en = PSEL && !PENABLE && !PWRITE;
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction
	flags_t m_flags_reg;
	flags_t c_flags_reg;
	logic c_expire_pulse;
	logic m_expire_pulse;
	flags_t m_set;
	flags_t c_set;
	// Master-side sources.
	always_comb
	begin
		m_set = '0;
		m_set[`M_BIT_CTRL_WD] = c_expire_pulse;
		m_set[`M_BIT_VEC_ERR] = src.vector_fetch_err;
		m_set[`M_BIT_OSC] = src.osc_missing;
		m_set[`M_BIT_ABUS] = src.analog_bus_err;
		m_set[`M_BIT_EXT] = src.ext_emergency;
		m_set[`M_BIT_MST_BIST] = src.master_selftest_err;
		m_set[`M_BIT_CTL_BIST] = src.control_selftest_err;
		if (wr_en && hit(PADDR, `OFF_M_FORCE))
			m_set = m_set | PWDATA[6:0];
	end
	// Control-side sources.
	always_comb
	begin
		c_set = '0;
		c_set[`C_BIT_OSC] = src.osc_missing;
		c_set[`C_BIT_ABUS] = src.analog_bus_err;
		c_set[`C_BIT_RAM] = src.ram_uncorrectable;
		c_set[`C_BIT_FLASH] = src.flash_uncorrectable;
		c_set[`C_BIT_VEC_ERR] = src.vector_fetch_err;
		c_set[`C_BIT_CTL_BIST] = src.control_selftest_err;
		c_set[`C_BIT_MST_BIST] = src.master_selftest_err;
		if (wr_en && hit(PADDR, `OFF_C_FORCE))
			c_set = c_set | PWDATA[6:0];
	end
	// Sticky flags: a set in the clearing cycle wins.
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			m_flags_reg <= `FLAGS_RST;
		else if (wr_en && hit(PADDR, `OFF_M_CLEAR))
			m_flags_reg <= (m_flags_reg & ~PWDATA[6:0]) | m_set;
		else
			m_flags_reg <= m_flags_reg | m_set;
	end
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			c_flags_reg <= `FLAGS_RST;
		else if (wr_en && hit(PADDR, `OFF_C_CLEAR))
			c_flags_reg <= (c_flags_reg & ~PWDATA[6:0]) | c_set;
		else
			c_flags_reg <= c_flags_reg | c_set;
	end
	// Rising edges of the flag summaries arm the watchdogs.
	logic m_any_reg;
	logic c_any_reg;
	logic m_rise;
	logic c_rise;
	assign m_rise = (|m_flags_reg) && !m_any_reg;
	assign c_rise = (|c_flags_reg) && !c_any_reg;
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			m_any_reg <= 1'b0;
			c_any_reg <= 1'b0;
		end
		else
		begin
			m_any_reg <= |m_flags_reg;
			c_any_reg <= |c_flags_reg;
		end
	end
	// Watchdog disable: writing one to bit 0 of the control register.
	logic m_dis;
	logic c_dis;
	assign m_dis = wr_en && hit(PADDR, `OFF_M_WDCTL) && PWDATA[0];
	assign c_dis = wr_en && hit(PADDR, `OFF_C_WDCTL) && PWDATA[0];
	wd_state_t m_st_reg;
	wd_state_t c_st_reg;
	logic [31:0] m_cnt_reg;
	logic [31:0] c_cnt_reg;
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			m_st_reg <= WD_IDLE;
			m_cnt_reg <= 32'h0000_0000;
		end
		else if (m_dis)
		begin
			m_st_reg <= WD_IDLE;
			m_cnt_reg <= 32'h0000_0000;
		end
		else
		begin
			unique case (m_st_reg)
				WD_IDLE:
					if (m_rise)
					begin
						m_st_reg <= WD_COUNT;
						m_cnt_reg <= 32'h0000_0000;
					end
				WD_COUNT:
					if (m_cnt_reg == WD_LOAD)
						m_st_reg <= WD_EXPIRED;
					else
						m_cnt_reg <= m_cnt_reg + 32'h0000_0001;
				WD_EXPIRED:
					m_st_reg <= WD_EXPIRED;
				default:
					m_st_reg <= WD_IDLE;
			endcase
		end
	end
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			c_st_reg <= WD_IDLE;
			c_cnt_reg <= 32'h0000_0000;
		end
		else if (c_dis)
		begin
			c_st_reg <= WD_IDLE;
			c_cnt_reg <= 32'h0000_0000;
		end
		else
		begin
			unique case (c_st_reg)
				WD_IDLE:
					if (c_rise)
					begin
						c_st_reg <= WD_COUNT;
						c_cnt_reg <= 32'h0000_0000;
					end
				WD_COUNT:
					if (c_cnt_reg == WD_LOAD)
						c_st_reg <= WD_EXPIRED;
					else
						c_cnt_reg <= c_cnt_reg + 32'h0000_0001;
				WD_EXPIRED:
					c_st_reg <= WD_EXPIRED;
				default:
					c_st_reg <= WD_IDLE;
			endcase
		end
	end
	assign m_expire_pulse = (m_st_reg == WD_COUNT) && (m_cnt_reg == WD_LOAD) && !m_dis;
	assign c_expire_pulse = (c_st_reg == WD_COUNT) && (c_cnt_reg == WD_LOAD) && !c_dis;
	// NMI and reset outputs, all registered.
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			NMI_OUT <= '0;
		else
		begin
			NMI_OUT.master_nmi_irq <= |m_flags_reg;
			NMI_OUT.master_nmi_wd_arm <= m_rise;
			NMI_OUT.master_nmi_wd_reset <= m_st_reg == WD_EXPIRED;
			NMI_OUT.control_nmi_irq <= |c_flags_reg;
			NMI_OUT.control_nmi_wd_arm <= c_rise;
			NMI_OUT.control_nmi_wd_reset <= c_st_reg == WD_EXPIRED;
			NMI_OUT.control_wd_reset_source <= c_st_reg == WD_EXPIRED;
		end
	end
	// Active-low reset pulse on the system reset pin.
	logic [4:0] pulse_cnt_reg;
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			pulse_cnt_reg <= 5'h00;
		else if (m_expire_pulse || (gen_wd_any && pulse_cnt_reg == 5'h00))
			pulse_cnt_reg <= 5'(`RST_PULSE_CYCLES);
		else if (pulse_cnt_reg != 5'h00)
			pulse_cnt_reg <= pulse_cnt_reg - 5'h01;
	end
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			RST_PIN_OUT <= 1'b1;
			RST_PIN_OE <= 1'b0;
		end
		else
		begin
			RST_PIN_OUT <= 1'b0;
			RST_PIN_OE <= pulse_cnt_reg != 5'h00;
		end
	end
	// Interrupt status: sticky, write one to clear, set wins.
	logic [3:0] ev_set;
	logic [3:0] irq_status_reg;
	logic [3:0] irq_mask_reg;
	assign ev_set = {c_expire_pulse, m_expire_pulse, c_rise, m_rise};
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			irq_status_reg <= 4'h0;
		else if (wr_en && hit(PADDR, `OFF_IRQ_STATUS))
			irq_status_reg <= (irq_status_reg & ~PWDATA[3:0]) | ev_set;
		else
			irq_status_reg <= irq_status_reg | ev_set;
	end
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			irq_mask_reg <= `MASK_RST;
		else if (wr_en && hit(PADDR, `OFF_IRQ_MASK))
			irq_mask_reg <= PWDATA[3:0];
	end
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			IRQ <= 1'b0;
		else
			IRQ <= |(irq_status_reg & irq_mask_reg);
	end
	// Read data is captured in the setup cycle and shown in the access cycle.
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
		else if (rd_en)
		begin
			PSLVERR <= 1'b0;
			unique case (PADDR)
				`OFF_M_FLAGS: PRDATA <= zext7(m_flags_reg);
				`OFF_C_FLAGS: PRDATA <= zext7(c_flags_reg);
				`OFF_M_WDCTL: PRDATA <= {30'h0000_0000, m_st_reg};
				`OFF_C_WDCTL: PRDATA <= {30'h0000_0000, c_st_reg};
				`OFF_IRQ_STATUS: PRDATA <= {28'h000_0000, irq_status_reg};
				`OFF_IRQ_MASK: PRDATA <= {28'h000_0000, irq_mask_reg};
				`OFF_WD_COUNT_M: PRDATA <= m_cnt_reg;
				`OFF_WD_COUNT_C: PRDATA <= c_cnt_reg;
				`OFF_M_CLEAR, `OFF_M_FORCE, `OFF_C_CLEAR, `OFF_C_FORCE: PRDATA <= 32'h0000_0000;
				default:
				begin
					PRDATA <= 32'h0000_0000;
					PSLVERR <= 1'b1;
				end
			endcase
		end
		else
			PSLVERR <= 1'b0;
	end
	always_ff @(posedge CORE_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			PREADY <= 1'b0;
		else
			PREADY <= PSEL && !PENABLE;
	end

	// Assertions.
	chk_master_irq_flag: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(|m_flags_reg) |=> NMI_OUT.master_nmi_irq) else $error("master irq missing");
	chk_control_irq_flag: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(|c_flags_reg) |=> NMI_OUT.control_nmi_irq) else $error("control irq missing");
	chk_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(m_flags_reg[0] && !(wr_en && PADDR == `OFF_M_CLEAR)) |=> m_flags_reg[0]) else $error("flag lost");
	chk_force_sets: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(wr_en && PADDR == `OFF_M_FORCE && PWDATA[2]) |=> m_flags_reg[2]) else $error("force ignored");
	chk_cforce_sets: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(wr_en && PADDR == `OFF_C_FORCE && PWDATA[3]) |=> c_flags_reg[3]) else $error("control force ignored");
	chk_wd_disable: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		m_dis |=> (m_st_reg == WD_IDLE && m_cnt_reg == 32'h0000_0000)) else $error("disable failed");
	chk_master_expire: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		m_expire_pulse |=> ##1 NMI_OUT.master_nmi_wd_reset) else $error("no master reset");
	chk_ctrl_feeds_master: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		c_expire_pulse |=> m_flags_reg[`M_BIT_CTRL_WD]) else $error("control expiry not fed");
	chk_pin_pulse: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		m_expire_pulse |=> ##1 RST_PIN_OE) else $error("no pin pulse");
	chk_ram_arms: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		(c_st_reg == WD_IDLE && !c_any_reg && src.ram_uncorrectable && !c_dis) |=> ##1 c_st_reg == WD_COUNT)
		else $error("ram error did not arm");
	cov_master_expire: cover property (@(posedge CORE_CLK) m_expire_pulse);
	cov_control_expire: cover property (@(posedge CORE_CLK) c_expire_pulse);
	cov_disable_in_time: cover property (@(posedge CORE_CLK) (m_st_reg == WD_COUNT) ##1 m_dis);
endmodule

/* nmi_far_side_model.sv */
module nmi_far_side_model
	import nmi_agg_pkg::*;
(
	// Clock.
	input  wire logic       clk,
	// Commands from the bench.
	input  wire err_src_t   src_cmd,
	input  wire logic [1:0] gen_cmd,
	// Lines into the block.
	output err_src_t        err_src,
	output logic      [1:0] gen_wd
);
	timeunit 1ns;
	timeprecision 1ps;

	// Memories, cores and clock monitors raise their faults as plain levels.
	always @(posedge clk)
	begin
		err_src <= src_cmd;
		gen_wd <= gen_cmd;
	end
endmodule

/* dual_nmi_aggregator_bench.sv */
`include "nmi_agg_regs.svh"
module dual_nmi_aggregator_bench
	import nmi_agg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WD = 200;
	localparam int PULSE = `RST_PULSE_CYCLES;
	// Expected master and control flags for each source bit, bit 7 first.
	localparam logic [55:0] M_TAB = {7'h10, 7'h08, 7'h04, 7'h02, 7'h00, 7'h00, 7'h20, 7'h40};
	localparam logic [55:0] C_TAB = {7'h00, 7'h02, 7'h01, 7'h10, 7'h04, 7'h08, 7'h40, 7'h20};
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	err_src_t    src_cmd;
	err_src_t    err_src;
	logic [1:0]  gen_cmd;
	logic [1:0]  gen_wd;
	nmi_out_t    nmi;
	logic        pin_out;
	logic        pin_oe;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          fail_count;
	int          total_checks;
	int          cycles;
	int          m_arms;
	int          c_arms;
	int          oe_cycles;

	dual_nmi_aggregator #(.WD_CYCLES(WD)) i_dut (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.ERR_SRC(err_src), .GEN_WD_EXPIRE(gen_wd), .NMI_OUT(nmi), .RST_PIN_OUT(pin_out), .RST_PIN_OE(pin_oe),
		.IRQ(irq));
	nmi_far_side_model i_far (.clk(clk), .src_cmd(src_cmd), .gen_cmd(gen_cmd), .err_src(err_src), .gen_wd(gen_wd));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic conclude();
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (nmi.master_nmi_wd_arm === 1'b1)
			m_arms++;
		if (nmi.control_nmi_wd_arm === 1'b1)
			c_arms++;
		if (pin_oe === 1'b1)
			oe_cycles++;
		if (cycles == 10000)
		begin
			fail_count++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task automatic t_reset();
		chk(nmi, 0);
		chk(pin_out, 1);
		chk(pin_oe, 0);
		chk(irq, 0);
		rdc(`OFF_M_FLAGS, 0);
		rdc(`OFF_C_FLAGS, 0);
		rdc(`OFF_IRQ_MASK, 0);
		rdc(`OFF_M_WDCTL, 0);
		chk(pin_out, 0);
		chk(pin_oe, 0);
	endtask

	task automatic t_sources();
		int ma;
		int ca;
		logic [6:0] mt;
		logic [6:0] ct;
		for (int i = 0; i < 8; i++)
		begin
			ma = m_arms;
			ca = c_arms;
			mt = M_TAB[i * 7 +: 7];
			ct = C_TAB[i * 7 +: 7];
			src_cmd <= err_src_t'(8'h01 << i);
			cyc(8);
			chk(nmi.master_nmi_irq, |mt);
			chk(nmi.control_nmi_irq, |ct);
			src_cmd <= '0;
			cyc(8);
			rdc(`OFF_M_FLAGS, mt);
			rdc(`OFF_C_FLAGS, ct);
			chk(m_arms - ma, |mt);
			chk(c_arms - ca, |ct);
			wr(`OFF_M_CLEAR, mt);
			wr(`OFF_C_CLEAR, ct);
			wr(`OFF_M_WDCTL, 1);
			wr(`OFF_C_WDCTL, 1);
			rdc(`OFF_M_FLAGS, 0);
			rdc(`OFF_C_FLAGS, 0);
		end
	endtask

	task automatic t_force();
		wr(`OFF_M_FORCE, 32'h0000_007F);
		rdc(`OFF_M_FLAGS, 32'h0000_007F);
		wr(`OFF_M_FLAGS, 32'h0000_0000);
		rdc(`OFF_M_FLAGS, 32'h0000_007F);
		wr(`OFF_M_CLEAR, 32'h0000_0005);
		rdc(`OFF_M_FLAGS, 32'h0000_007A);
		wr(`OFF_C_FORCE, 32'h0000_0041);
		rdc(`OFF_C_FLAGS, 32'h0000_0041);
		wr(`OFF_C_CLEAR, 32'h0000_007F);
		wr(`OFF_M_CLEAR, 32'h0000_007F);
		rdc(`OFF_C_FLAGS, 0);
		wr(`OFF_M_WDCTL, 1);
		wr(`OFF_C_WDCTL, 1);
	endtask

	task automatic t_master_expire();
		oe_cycles = 0;
		wr(`OFF_M_FORCE, 32'h0000_0010);
		cyc(5);
		rdc(`OFF_M_WDCTL, 1);
		chk(nmi.master_nmi_wd_reset, 0);
		cyc(WD + 10);
		chk(nmi.master_nmi_wd_reset, 1);
		rdc(`OFF_M_WDCTL, 2);
		chk(oe_cycles, PULSE);
		chk(pin_out, 0);
		wr(`OFF_M_WDCTL, 1);
		cyc(2);
		chk(nmi.master_nmi_wd_reset, 0);
		rdc(`OFF_M_WDCTL, 0);
		wr(`OFF_M_CLEAR, 32'h0000_007F);
	endtask

	task automatic t_ctrl_expire();
		wr(`OFF_C_FORCE, 32'h0000_0001);
		cyc(WD + 10);
		chk(nmi.control_nmi_wd_reset, 1);
		chk(nmi.control_wd_reset_source, 1);
		rdc(`OFF_M_FLAGS, 32'h0000_0001);
		chk(nmi.master_nmi_irq, 1);
		wr(`OFF_C_WDCTL, 1);
		cyc(8);
		chk(nmi.control_nmi_wd_reset, 0);
		chk(nmi.control_wd_reset_source, 0);
		wr(`OFF_M_CLEAR, 32'h0000_007F);
		wr(`OFF_C_CLEAR, 32'h0000_007F);
		wr(`OFF_M_WDCTL, 1);
	endtask

	task automatic t_early_disable();
		wr(`OFF_M_FORCE, 32'h0000_0002);
		cyc(20);
		wr(`OFF_M_WDCTL, 1);
		wr(`OFF_M_CLEAR, 32'h0000_007F);
		cyc(WD + 10);
		chk(nmi.master_nmi_wd_reset, 0);
		rdc(`OFF_M_WDCTL, 0);
	endtask

	task automatic t_gen_wd();
		for (int j = 0; j < 2; j++)
		begin
			oe_cycles = 0;
			gen_cmd <= 2'h1 << j;
			cyc(4);
			gen_cmd <= 2'h0;
			cyc(30);
			chk(oe_cycles, PULSE);
		end
	endtask

	task automatic t_irq();
		rdc(`OFF_IRQ_STATUS, 32'h0000_000F);
		chk(irq, 0);
		for (int k = 0; k < 4; k++)
		begin
			wr(`OFF_IRQ_MASK, 32'h1 << k);
			cyc(2);
			chk(irq, 1);
		end
		wr(`OFF_IRQ_MASK, 32'h0000_0000);
		cyc(2);
		chk(irq, 0);
		wr(`OFF_IRQ_STATUS, 32'h0000_000F);
		rdc(`OFF_IRQ_STATUS, 0);
		wr(`OFF_IRQ_MASK, 32'h0000_000F);
		cyc(2);
		chk(irq, 0);
	endtask

	task automatic t_unmapped();
		apb(1'b0, 12'h030, 32'h0000_0000);
		chk(err, 1);
		chk(rd, 0);
		wr(12'h030, 32'hFFFF_FFFF);
		rdc(`OFF_IRQ_MASK, 32'h0000_000F);
		chk(err, 0);
	endtask

	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		src_cmd = '0;
		gen_cmd = 2'h0;
		fail_count = 0;
		total_checks = 0;
		cycles = 0;
		m_arms = 0;
		c_arms = 0;
		oe_cycles = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_sources();
		t_force();
		t_master_expire();
		t_ctrl_expire();
		t_early_disable();
		t_gen_wd();
		t_irq();
		t_unmapped();
		conclude();
	end
endmodule
